/* logic/exc_pkg.sv */
// Purpose: Shared constants and types for exception stacking and sleep logic
// Assumes: 32-bit APB, word-aligned registers, byte addresses below
// Notes:   Register map and bit positions are local to this block
// Contract
// - Exception entry pushes eight 32-bit words: status, return, link, R12, R3-R0.
// - Thread mode picks main or process stack from the select bit.
// - Handler mode always uses the main stack, also when nesting.
// - Stack pointer decrements on push and addresses the last pushed word.
// - All eight writes finish before handler mode begins.
// - Wakeup controller wakes the core on any enabled wake source; in event sleep with the priority mask bit set, the code ignores interrupts.
// - Wait-for-interrupt or wait-for-event puts the core to sleep or deep sleep.
// - Event sleep wakes on interrupt only with mask clear; interrupt sleep ignores mask.
// - Wait-for-event sleeps by the event latch and wakes on core events.
// - Interrupt sleep never wakes on an event from the other core.
// - Deep sleep wakes only from watchdog, clock, GPIO and comparator sources, or on an event when entered by wait-for-event.
// - Reset clears the event latch.
// - Wakeup events and exception returns set the event latch.
// - Wait-for-event clears the latch unless an event arrives in the same cycle; a set latch means no sleep.
// - Software cannot read or write the event latch.
// - Priority mask bit set blocks servicing; requests stay pending.
package exc_pkg;

  localparam int             IRQ_N       = 8;
  localparam int             STACK_DEPTH = 64;
  localparam int             ADDR_LSB    = 2;
  localparam int             FRAME_WORDS = 8;
  localparam logic [2:0]     FRAME_LAST  = 3'h7;
  localparam logic [3:0]     DEPTH_ONE   = 4'h1;
  localparam logic [3:0]     DEPTH_MAX   = 4'hF;
  // Watchdog, clock, GPIO, comparator on sources 0..3
  localparam logic [IRQ_N-1:0] DEEP_WAKE_MASK = 8'h0F;

  localparam logic [31:0]    SP_STEP     = 32'h0000_0004;
  localparam logic [31:0]    MAIN_SP_RST = 32'h0000_0100;
  localparam logic [31:0]    PROC_SP_RST = 32'h0000_00C0;
  localparam logic [31:0]    ZERO_WORD   = 32'h0000_0000;

  localparam logic [7:0]     OFS_CTRL    = 8'h00;
  localparam logic [7:0]     OFS_CMD     = 8'h04;
  localparam logic [7:0]     OFS_STATUS  = 8'h08;
  localparam logic [7:0]     OFS_MAIN_SP = 8'h0C;
  localparam logic [7:0]     OFS_PROC_SP = 8'h10;
  localparam logic [7:0]     OFS_IRQ_EN  = 8'h14;
  localparam logic [7:0]     OFS_FRAME   = 8'h20;

  localparam int             CTRL_SPSEL  = 0;
  localparam int             CTRL_MASK   = 1;
  localparam int             CTRL_DEEP   = 2;
  localparam logic [2:0]     CTRL_RST    = 3'h0;

  localparam int             CMD_EXC     = 0;
  localparam int             CMD_RET     = 1;
  localparam int             CMD_WAIT_IRQ = 2;
  localparam int             CMD_WAIT_EVT = 3;

  typedef enum logic [1:0] {
    ST_RUN   = 2'h0,
    ST_PUSH  = 2'h1,
    ST_POP   = 2'h3,
    ST_SLEEP = 2'h2
  } core_state_t;

  typedef struct packed {
    logic [22:0] rsvd;
    logic [3:0]  depth;
    logic        sp_proc;
    logic        deep;
    logic        sleeping;
    logic        popping;
    logic        pushing;
  } status_t;

endpackage

/* logic/wake_ctrl.sv */
// Purpose: Wakeup controller deciding when a sleeping core returns to active
// Assumes: Pending vector already gated by the per-source enables
// Notes:   Purely combinational; caller qualifies with its sleep state
module wake_ctrl #(
  parameter int               IRQ_N     = exc_pkg::IRQ_N,
  parameter logic [IRQ_N-1:0] DEEP_MASK = exc_pkg::DEEP_WAKE_MASK
) (
  input  wire logic [IRQ_N-1:0] pend,
  input  wire logic             deep,
  input  wire logic             by_evt,
  input  wire logic             priority_mask_bit,
  input  wire logic             event_in,
  output logic                  wake
);

  logic [IRQ_N-1:0] src;
  logic             irq_ok;

  assign src = deep ? (pend & DEEP_MASK) : pend;

  assign irq_ok = (|src) && (!by_evt || !priority_mask_bit);

  assign wake = irq_ok || (by_evt && event_in);

endmodule // wake_ctrl

/* logic/exc_stack_sleep.sv */
// Purpose: Exception stacking, stack pointer select, sleep and event latch
// Assumes: APB master per protocol; irq_src and event_in synchronous to pclk
// Notes:   Stack frame kept in a local word array addressed by the pointers
//
// Our own choices: the placing of the registers and the APB interface to the registers.
module exc_stack_sleep #(
  parameter int               IRQ_N       = exc_pkg::IRQ_N,
  parameter int               STACK_DEPTH = exc_pkg::STACK_DEPTH,
  parameter logic [IRQ_N-1:0] DEEP_MASK   = exc_pkg::DEEP_WAKE_MASK
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [IRQ_N-1:0] irq_src,
  input  wire logic             event_in,
  output logic                  handler_mode,
  output logic                  sleeping,
  output logic                  deep_sleeping,
  output logic                  wake,
  output logic                  stacking
);

  localparam int SW = $clog2(STACK_DEPTH);

  exc_pkg::core_state_t state_r;
  exc_pkg::core_state_t state_nxt;
  exc_pkg::status_t     status;

  logic [2:0]       cnt_r;
  logic [31:0]      main_sp_r;
  logic [31:0]      proc_sp_r;
  logic [2:0]       ctrl_r;
  logic [IRQ_N-1:0] irq_en_r;
  logic [3:0]       depth_r;
  logic             thread_proc_r;
  logic             sleep_evt_r;
  logic             deep_r;
  logic             event_r;
  logic             sw_pend_r;
  logic [31:0]      prdata_r;
  logic [31:0]      frame_r [exc_pkg::FRAME_WORDS];
  logic [31:0]      stack_mem [STACK_DEPTH];

  logic             wr_acc;
  logic             cmd_wr;
  logic             cmd_exc;
  logic             cmd_ret;
  logic             cmd_wait_irq;
  logic             cmd_wait_evt;
  logic             handler;
  logic             priority_mask_bit;
  logic [IRQ_N-1:0] pend;
  logic             take;
  logic             go_pop;
  logic             go_push;
  logic             irq_wait_exec;
  logic             evt_wait_exec;
  logic             cur_proc;
  logic [31:0]      cur_sp;
  logic [31:0]      push_data;
  logic             last_beat;
  logic             wake_raw;
  logic [31:0]      rd_word;

  function automatic logic [SW-1:0] word_idx(input logic [31:0] a);
    word_idx = a[exc_pkg::ADDR_LSB +: SW];
  endfunction

  function automatic logic frame_hit(input logic [7:0] a);
    frame_hit = (a[7:5] == exc_pkg::OFS_FRAME[7:5]);
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == exc_pkg::OFS_CTRL) || (a == exc_pkg::OFS_CMD) ||
              (a == exc_pkg::OFS_STATUS) || (a == exc_pkg::OFS_MAIN_SP) ||
              (a == exc_pkg::OFS_PROC_SP) || (a == exc_pkg::OFS_IRQ_EN) ||
              frame_hit(a);
  endfunction

  // Bus decode
  assign wr_acc  = psel && penable && pwrite;
  assign cmd_wr  = wr_acc && (paddr == exc_pkg::OFS_CMD);
  assign cmd_exc = cmd_wr && pwdata[exc_pkg::CMD_EXC];
  assign cmd_ret = cmd_wr && pwdata[exc_pkg::CMD_RET];
  assign cmd_wait_irq = cmd_wr && pwdata[exc_pkg::CMD_WAIT_IRQ];
  assign cmd_wait_evt = cmd_wr && pwdata[exc_pkg::CMD_WAIT_EVT];

  assign handler   = (depth_r != 4'h0);
  assign priority_mask_bit = ctrl_r[exc_pkg::CTRL_MASK];
  assign pend      = irq_src & irq_en_r;
  assign last_beat = (cnt_r == exc_pkg::FRAME_LAST);

  assign take = !priority_mask_bit && (depth_r != exc_pkg::DEPTH_MAX) &&
                (sw_pend_r || (!handler && (|pend)));

  assign go_pop   = (state_r == exc_pkg::ST_RUN) && cmd_ret && handler;
  assign go_push  = (state_r == exc_pkg::ST_RUN) && !go_pop && take;
  assign irq_wait_exec = (state_r == exc_pkg::ST_RUN) && !go_pop && !go_push && cmd_wait_irq;
  assign evt_wait_exec = (state_r == exc_pkg::ST_RUN) && !go_pop && !go_push &&
                         !cmd_wait_irq && cmd_wait_evt;

  always_comb begin
    if (state_r == exc_pkg::ST_POP) begin
      cur_proc = (depth_r == exc_pkg::DEPTH_ONE) && thread_proc_r;
    end else begin
      cur_proc = !handler && ctrl_r[exc_pkg::CTRL_SPSEL];
    end
  end

  assign cur_sp    = cur_proc ? proc_sp_r : main_sp_r;
  assign push_data = frame_r[cnt_r];

  wake_ctrl #(
    .IRQ_N     (IRQ_N),
    .DEEP_MASK (DEEP_MASK)
  ) u_wake (
    .pend     (pend),
    .deep     (deep_r),
    .by_evt            (sleep_evt_r),
    .priority_mask_bit (priority_mask_bit),
    .event_in (event_in),
    .wake     (wake_raw)
  );

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      exc_pkg::ST_RUN: begin
        if (go_pop) begin
          state_nxt = exc_pkg::ST_POP;
        end else if (go_push) begin
          state_nxt = exc_pkg::ST_PUSH;
        end else if (irq_wait_exec || (evt_wait_exec && !event_r)) begin
          state_nxt = exc_pkg::ST_SLEEP;
        end
      end
      exc_pkg::ST_PUSH, exc_pkg::ST_POP: begin
        if (last_beat) begin
          state_nxt = exc_pkg::ST_RUN;
        end
      end
      exc_pkg::ST_SLEEP: begin
        if (wake_raw) begin
          state_nxt = exc_pkg::ST_RUN;
        end
      end
      default: state_nxt = exc_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= exc_pkg::ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Beat counter for the eight frame words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 3'h0;
    end else if (state_r == exc_pkg::ST_PUSH || state_r == exc_pkg::ST_POP) begin
      cnt_r <= cnt_r + 3'h1;
    end else begin
      cnt_r <= 3'h0;
    end
  end

  // word written below the active pointer
  always_ff @(posedge pclk) begin
    if (state_r == exc_pkg::ST_PUSH) begin
      stack_mem[word_idx(cur_sp - exc_pkg::SP_STEP)] <= push_data;
    end
  end

  // pointers move one word per beat
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_sp_r <= exc_pkg::MAIN_SP_RST;
      proc_sp_r <= exc_pkg::PROC_SP_RST;
    end else if (state_r == exc_pkg::ST_PUSH) begin
      if (cur_proc) begin
        proc_sp_r <= cur_sp - exc_pkg::SP_STEP;
      end else begin
        main_sp_r <= cur_sp - exc_pkg::SP_STEP;
      end
    end else if (state_r == exc_pkg::ST_POP) begin
      if (cur_proc) begin
        proc_sp_r <= cur_sp + exc_pkg::SP_STEP;
      end else begin
        main_sp_r <= cur_sp + exc_pkg::SP_STEP;
      end
    end else if (wr_acc && paddr == exc_pkg::OFS_MAIN_SP) begin
      main_sp_r <= pwdata;
    end else if (wr_acc && paddr == exc_pkg::OFS_PROC_SP) begin
      proc_sp_r <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < exc_pkg::FRAME_WORDS; i++) begin
        frame_r[i] <= exc_pkg::ZERO_WORD;
      end
    end else if (state_r == exc_pkg::ST_POP) begin
      frame_r[exc_pkg::FRAME_LAST - cnt_r] <= stack_mem[word_idx(cur_sp)];
    end else if (state_r == exc_pkg::ST_RUN && wr_acc && frame_hit(paddr)) begin
      frame_r[paddr[4:2]] <= pwdata;
    end
  end

  // handler mode only after the last push
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth_r       <= 4'h0;
      thread_proc_r <= 1'b0;
    end else begin
      if (go_push && !handler) begin
        thread_proc_r <= ctrl_r[exc_pkg::CTRL_SPSEL];
      end
      if (state_r == exc_pkg::ST_PUSH && last_beat) begin
        depth_r <= depth_r + 4'h1;
      end else if (state_r == exc_pkg::ST_POP && last_beat) begin
        depth_r <= depth_r - 4'h1;
      end
    end
  end

  // Software exception request, set wins over consume
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_pend_r <= 1'b0;
    end else begin
      sw_pend_r <= cmd_exc || (sw_pend_r && !go_push);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_evt_r <= 1'b0;
      deep_r      <= 1'b0;
    end else if (state_r == exc_pkg::ST_RUN && state_nxt == exc_pkg::ST_SLEEP) begin
      sleep_evt_r <= !irq_wait_exec;
      deep_r      <= ctrl_r[exc_pkg::CTRL_DEEP];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_r <= 1'b0;
    end else if (event_in || (state_r == exc_pkg::ST_POP && last_beat)) begin
      event_r <= 1'b1;
    end else if (evt_wait_exec) begin
      event_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= exc_pkg::CTRL_RST;
      irq_en_r <= '0;
    end else if (wr_acc && paddr == exc_pkg::OFS_CTRL) begin
      ctrl_r <= pwdata[2:0];
    end else if (wr_acc && paddr == exc_pkg::OFS_IRQ_EN) begin
      irq_en_r <= pwdata[IRQ_N-1:0];
    end
  end

  always_comb begin
    status          = '0;
    status.depth    = depth_r;
    status.sp_proc  = cur_proc;
    status.deep     = (state_r == exc_pkg::ST_SLEEP) && deep_r;
    status.sleeping = (state_r == exc_pkg::ST_SLEEP);
    status.popping  = (state_r == exc_pkg::ST_POP);
    status.pushing  = (state_r == exc_pkg::ST_PUSH);
  end

  // no path to the event latch
  always_comb begin
    rd_word = exc_pkg::ZERO_WORD;
    if (frame_hit(paddr)) begin
      rd_word = frame_r[paddr[4:2]];
    end else begin
      case (paddr)
        exc_pkg::OFS_CTRL:   rd_word = {29'h0, ctrl_r};
        exc_pkg::OFS_STATUS: rd_word = status;
        exc_pkg::OFS_MAIN_SP: rd_word = main_sp_r;
        exc_pkg::OFS_PROC_SP: rd_word = proc_sp_r;
        exc_pkg::OFS_IRQ_EN: rd_word = {{(32-IRQ_N){1'b0}}, irq_en_r};
        default:             rd_word = exc_pkg::ZERO_WORD;
      endcase
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= exc_pkg::ZERO_WORD;
    end else if (psel && !penable) begin
      prdata_r <= rd_word;
    end
  end

  assign prdata        = prdata_r;
  assign pready        = 1'b1;
  assign pslverr       = psel && penable && !reg_hit(paddr);
  assign handler_mode  = handler;
  assign sleeping      = (state_r == exc_pkg::ST_SLEEP);
  assign deep_sleeping = sleeping && deep_r;
  assign wake          = sleeping && wake_raw;
  assign stacking      = (state_r == exc_pkg::ST_PUSH) || (state_r == exc_pkg::ST_POP);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_push_eight_beats:
    assert property ($rose(state_r == exc_pkg::ST_PUSH) |->
                     (state_r == exc_pkg::ST_PUSH)[*8] ##1 (state_r == exc_pkg::ST_RUN))
    else $error("push did not last eight beats");

  a_thread_sel_proc:
    assert property ((state_r == exc_pkg::ST_PUSH && !handler && ctrl_r[exc_pkg::CTRL_SPSEL]) |=>
                     (proc_sp_r == $past(proc_sp_r) - exc_pkg::SP_STEP) && (main_sp_r == $past(main_sp_r)))
    else $error("thread push used wrong pointer");

  a_handler_main_sp:
    assert property ((state_r == exc_pkg::ST_PUSH && handler) |=>
                     (proc_sp_r == $past(proc_sp_r)) && (main_sp_r == $past(main_sp_r) - exc_pkg::SP_STEP))
    else $error("handler push did not use main pointer");

  a_sp_last_word:
    assert property ((state_r == exc_pkg::ST_PUSH && !last_beat) |=>
                     stack_mem[word_idx(cur_sp)] == $past(push_data))
    else $error("pointer not at last pushed word");

  a_handler_after_push:
    assert property ($rose(handler) |-> $past(state_r == exc_pkg::ST_PUSH && last_beat))
    else $error("handler mode before stacking done");

  a_irq_sleep_wake:
    assert property ((sleeping && !sleep_evt_r && !deep_r && (|pend)) |->
                     wake ##1 (state_r == exc_pkg::ST_RUN))
    else $error("interrupt sleep missed a wake");

  a_irq_sleep_no_evt:
    assert property ((sleeping && !sleep_evt_r && pend == '0) |-> !wake)
    else $error("interrupt sleep woke without interrupt");

  a_deep_sources:
    assert property ((sleeping && deep_r && !sleep_evt_r && (pend & DEEP_MASK) == '0) |-> !wake)
    else $error("deep sleep woke from non-deep source");

  a_evt_skip_sleep:
    assert property ((evt_wait_exec && event_r && !event_in) |=>
                     !event_r && (state_r == exc_pkg::ST_RUN))
    else $error("set latch not consumed without sleep");

  a_evt_enters_sleep:
    assert property ((evt_wait_exec && !event_r) |=> sleeping && sleep_evt_r)
    else $error("clear latch did not sleep");

  a_return_sets_event:
    assert property ((state_r == exc_pkg::ST_POP && last_beat) |=> event_r)
    else $error("exception return left latch clear");

  a_mask_blocks_entry:
    assert property ((state_r == exc_pkg::ST_RUN && priority_mask_bit && !go_pop) |=>
                     state_r != exc_pkg::ST_PUSH)
    else $error("entry taken while masked");

endmodule // exc_stack_sleep

/* testbench/far_side.sv */
// Purpose: Far-side model: peripheral interrupt lines and the other core
// Assumes: Bench requests; outputs change just after pclk rises
// Notes:   One event pulse per rising edge of ev_req
module far_side (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] irq_req,
  input  wire logic       ev_req,
  output logic      [7:0] irq_src,
  output logic            event_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_src  <= 8'h00;
      ev_q     <= 1'h0;
      event_in <= 1'h0;
    end else begin
      irq_src  <= irq_req;
      ev_q     <= ev_req;
      event_in <= ev_req & ~ev_q;
    end
  end
endmodule // far_side

/* testbench/tb_top.sv */
// Purpose: Self-checking bench for exception stacking and sleep logic
// Assumes: Zero or more APB wait states, far side registered
// Notes:   Each scenario drives and judges before returning
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, irq_req, irq_src;
  logic [31:0] pwdata, prdata;
  logic        ev_req, event_in, handler_mode, sleeping, deep_sleeping, wake, stacking;
  int          err_count, num_checks;

  exc_stack_sleep DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_src(irq_src), .event_in(event_in), .handler_mode(handler_mode),
    .sleeping(sleeping), .deep_sleeping(deep_sleeping), .wake(wake), .stacking(stacking));
  far_side peer (.pclk(pclk), .presetn(presetn), .irq_req(irq_req), .ev_req(ev_req),
    .irq_src(irq_src), .event_in(event_in));

  always #5 pclk = ~pclk;

  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic chb(input string nm, input logic x, input logic g);
    chk(nm, {31'h0000_0000, x}, {31'h0000_0000, g});
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) err_count++;
    q = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'h1, a, d, q, e);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'h0, a, 32'h0000_0000, q, e);
    chk(nm, x, q);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic beats(input logic hm_in, input logic hm_out);
    int n;
    n = 0;
    for (int i = 0; i < 30; i++) begin
      @(negedge pclk);
      if (stacking === 1'h1) begin
        n++;
        if (n == 4) chb("handler_mid", hm_in, handler_mode);
      end else if (n > 0) break;
    end
    chk("beats", 32'h0000_0008, 32'(n));
    chb("handler_after", hm_out, handler_mode);
  endtask

  task automatic t_reset;
    logic [31:0] q;
    logic        e;
    ev_req <= 1'h1;
    cyc(2);
    @(posedge pclk);
    ev_req  <= 1'h0;
    presetn <= 1'h0;
    cyc(2);
    @(posedge pclk);
    presetn <= 1'h1;
    rdc("ctrl", exc_pkg::OFS_CTRL, 32'h0000_0000);
    rdc("main_sp", exc_pkg::OFS_MAIN_SP, exc_pkg::MAIN_SP_RST);
    rdc("proc_sp", exc_pkg::OFS_PROC_SP, exc_pkg::PROC_SP_RST);
    wr(exc_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    rdc("status", exc_pkg::OFS_STATUS, 32'h0000_0000);
    apb(1'h0, 8'h18, 32'h0000_0000, q, e);
    chb("slverr", 1'h1, e);
    chk("unmapped", 32'h0000_0000, q);
    wr(exc_pkg::OFS_CMD, 32'h0000_0008);
    cyc(2);
    chb("sleep_after_reset", 1'h1, sleeping);
    @(posedge pclk);
    ev_req <= 1'h1;
    cyc(3);
    chb("event_wake", 1'h0, sleeping);
    @(posedge pclk);
    ev_req <= 1'h0;
  endtask

  task automatic t_stack;
    // all eight frame words set at run time
    for (int k = 0; k < 8; k++) wr(exc_pkg::OFS_FRAME + 8'(4 * k), 32'hA5A5_0000 + 32'(k));
    wr(exc_pkg::OFS_CTRL, 32'h0000_0001);
    wr(exc_pkg::OFS_CMD, 32'h0000_0001);
    beats(1'h0, 1'h1);
    rdc("proc_sp", exc_pkg::OFS_PROC_SP, exc_pkg::PROC_SP_RST - 32'h0000_0020);
    rdc("main_sp", exc_pkg::OFS_MAIN_SP, exc_pkg::MAIN_SP_RST);
    rdc("status", exc_pkg::OFS_STATUS, 32'h0000_0020);
    for (int k = 0; k < 8; k++) wr(exc_pkg::OFS_FRAME + 8'(4 * k), 32'h0000_0000);
    wr(exc_pkg::OFS_CMD, 32'h0000_0001);
    beats(1'h1, 1'h1);
    rdc("main_sp", exc_pkg::OFS_MAIN_SP, exc_pkg::MAIN_SP_RST - 32'h0000_0020);
    rdc("proc_sp", exc_pkg::OFS_PROC_SP, exc_pkg::PROC_SP_RST - 32'h0000_0020);
    rdc("status", exc_pkg::OFS_STATUS, 32'h0000_0040);
    wr(exc_pkg::OFS_CMD, 32'h0000_0002);
    beats(1'h1, 1'h1);
    rdc("main_sp", exc_pkg::OFS_MAIN_SP, exc_pkg::MAIN_SP_RST);
    wr(exc_pkg::OFS_CMD, 32'h0000_0002);
    beats(1'h1, 1'h0);
    rdc("proc_sp", exc_pkg::OFS_PROC_SP, exc_pkg::PROC_SP_RST);
    for (int k = 0; k < 8; k++) rdc("frame", exc_pkg::OFS_FRAME + 8'(4 * k), 32'hA5A5_0000 + 32'(k));
    rdc("status", exc_pkg::OFS_STATUS, 32'h0000_0010);
    wr(exc_pkg::OFS_CTRL, 32'h0000_0000);
  endtask

  task automatic t_wfi;
    wr(exc_pkg::OFS_IRQ_EN, 32'h0000_00FF);
    wr(exc_pkg::OFS_CTRL, 32'h0000_0002);
    wr(exc_pkg::OFS_CMD, 32'h0000_0004);
    cyc(2);
    chb("irq_sleep", 1'h1, sleeping);
    @(posedge pclk);
    ev_req <= 1'h1;
    cyc(4);
    chb("irq_sleep_no_event", 1'h1, sleeping);
    chb("wake_idle", 1'h0, wake);
    @(posedge pclk);
    irq_req <= 8'h20;
    cyc(3);
    chb("irq_masked_wake", 1'h0, sleeping);
    cyc(14);
    chb("masked_held", 1'h0, handler_mode);
    wr(exc_pkg::OFS_CTRL, 32'h0000_0000);
    cyc(14);
    chb("unmasked_taken", 1'h1, handler_mode);
    @(posedge pclk);
    irq_req <= 8'h00;
    wr(exc_pkg::OFS_CMD, 32'h0000_0002);
    cyc(14);
  endtask

  task automatic t_wfe;
    ev_req <= 1'h0;
    wr(exc_pkg::OFS_CTRL, 32'h0000_0002);
    wr(exc_pkg::OFS_CMD, 32'h0000_0008);
    cyc(2);
    chb("evt_latched", 1'h0, sleeping);
    wr(exc_pkg::OFS_CMD, 32'h0000_0008);
    cyc(2);
    chb("evt_second", 1'h1, sleeping);
    @(posedge pclk);
    irq_req <= 8'h01;
    cyc(4);
    chb("evt_masked", 1'h1, sleeping);
    @(posedge pclk);
    ev_req <= 1'h1;
    cyc(3);
    chb("evt_event", 1'h0, sleeping);
    @(posedge pclk);
    irq_req <= 8'h00;
    ev_req  <= 1'h0;
    wr(exc_pkg::OFS_CMD, 32'h0000_0008);
    cyc(2);
    chb("evt_after_wake", 1'h0, sleeping);
    wr(exc_pkg::OFS_CTRL, 32'h0000_0000);
    wr(exc_pkg::OFS_CMD, 32'h0000_0008);
    cyc(2);
    chb("evt_again", 1'h1, sleeping);
    @(posedge pclk);
    irq_req <= 8'h02;
    cyc(3);
    chb("evt_irq_wake", 1'h0, sleeping);
    cyc(14);
    chb("evt_handler", 1'h1, handler_mode);
    @(posedge pclk);
    irq_req <= 8'h00;
    wr(exc_pkg::OFS_CMD, 32'h0000_0002);
    cyc(14);
  endtask

  task automatic t_deep;
    wr(exc_pkg::OFS_CTRL, 32'h0000_0004);
    wr(exc_pkg::OFS_CMD, 32'h0000_0004);
    cyc(2);
    chb("deep", 1'h1, deep_sleeping);
    @(posedge pclk);
    irq_req <= 8'h30;
    cyc(4);
    chb("deep_ignored", 1'h1, sleeping);
    @(posedge pclk);
    irq_req <= 8'h38;
    cyc(3);
    chb("deep_wake", 1'h0, sleeping);
    @(posedge pclk);
    irq_req <= 8'h00;
    cyc(14);
    chb("deep_handler", 1'h1, handler_mode);
    wr(exc_pkg::OFS_CMD, 32'h0000_0002);
    cyc(14);
    chb("deep_return", 1'h0, handler_mode);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    finish_test;
  end

  initial begin
    pclk    = 1'h0;
    presetn = 1'h0;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    irq_req = 8'h00;
    ev_req  = 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    t_reset;
    t_stack;
    t_wfi;
    t_wfe;
    t_deep;
    finish_test;
  end
endmodule // tb_top
